// ### logic/dcc_channel.sv
// transfer count and address pointers of one dma channel, with an ahb-lite register slave
`include "dcc_regs.svh"

module dcc_channel (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        channel_enable,
  input  wire logic        cyclic_mode,
  input  wire logic [1:0]  peripheral_width,
  input  wire logic [1:0]  memory_width,
  input  wire logic        transfer_done,
  output logic             transfer_permit,
  output logic             block_end,
  output logic [31:0]      peripheral_access_addr,
  output logic [31:0]      memory_access_addr
);

  // ----------------------------------------------------------------
  // decode and alignment helpers
  // ----------------------------------------------------------------

  // map a bus address onto one of the three registers
  function automatic dcc_pkg::dcc_sel_e reg_sel(input logic [31:0] addr);
    logic [11:0] ofs;
    ofs = {addr[`DCC_ADDR_MSB:`DCC_ADDR_LSB], 2'b00};
    case (ofs)
      `DCC_OFS_COUNT:  reg_sel = dcc_pkg::DCC_SEL_COUNT;
      `DCC_OFS_PERIPH: reg_sel = dcc_pkg::DCC_SEL_PERIPH;
      `DCC_OFS_MEMORY: reg_sel = dcc_pkg::DCC_SEL_MEMORY;
      default:         reg_sel = dcc_pkg::DCC_SEL_NONE;
    endcase
  endfunction : reg_sel

  // clear the low address bits that the access width does not use
  function automatic logic [31:0] align_addr(input logic [31:0] addr, input logic [1:0] width);
    case (width)
      `DCC_WIDTH_HALF: align_addr = addr & `DCC_HALF_MASK;
      `DCC_WIDTH_WORD: align_addr = addr & `DCC_WORD_MASK;
      default:         align_addr = addr; // byte, and the reserved code left unaligned
    endcase
  endfunction : align_addr

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dcc_pkg::dcc_count_t transfer_count;
  dcc_pkg::dcc_count_t reload_count;
  logic [31:0]         peripheral_address;
  logic [31:0]         memory_address;
  logic                wr_pend;
  dcc_pkg::dcc_sel_e   wr_sel;
  logic                rd_pend;
  dcc_pkg::dcc_sel_e   rd_sel;
  logic                addr_phase;
  logic                last_done;
  logic [31:0]         next_rdata;

  assign addr_phase = hsel && htrans[1] && hready;
  // a completed transfer ends the block only while enabled with one transfer outstanding
  assign last_done  = transfer_done && channel_enable && (transfer_count == 16'h0001);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------

  // capture address phases; reads get one wait state so a preceding write lands first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      wr_sel    <= dcc_pkg::DCC_SEL_NONE;
      rd_pend   <= 1'b0;
      rd_sel    <= dcc_pkg::DCC_SEL_NONE;
      hreadyout <= 1'b0;
    end
    else
    begin
      wr_pend   <= addr_phase && hwrite;
      wr_sel    <= reg_sel(haddr);
      rd_pend   <= addr_phase && !hwrite;
      rd_sel    <= reg_sel(haddr);
      hreadyout <= !(addr_phase && !hwrite); // low during the first read data cycle
    end
  end

  // response is always okay, unmapped addresses included
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp <= `DCC_HRESP_OKAY;
    end
    else
    begin
      hresp <= `DCC_HRESP_OKAY;
    end
  end

  // read multiplexer, unmapped reads return zero
  always_comb
  begin
    case (rd_sel)
      dcc_pkg::DCC_SEL_COUNT:  next_rdata = {`DCC_RESV_ZERO, transfer_count};
      dcc_pkg::DCC_SEL_PERIPH: next_rdata = peripheral_address;
      dcc_pkg::DCC_SEL_MEMORY: next_rdata = memory_address;
      default:                 next_rdata = 32'h0000_0000;
    endcase
  end

  // read data register, loaded in the wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend)
    begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // transfer count
  // ----------------------------------------------------------------

  // programmed value kept for cyclic reload
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reload_count <= `DCC_COUNT_RESET;
    end
    else if (wr_pend && wr_sel == dcc_pkg::DCC_SEL_COUNT && !channel_enable)
    begin
      reload_count <= hwdata[`DCC_COUNT_MSB:0];
    end
  end

  // software load while idle, countdown while enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      transfer_count <= `DCC_COUNT_RESET;
    end
    else if (wr_pend && wr_sel == dcc_pkg::DCC_SEL_COUNT && !channel_enable)
    begin
      transfer_count <= hwdata[`DCC_COUNT_MSB:0];
    end
    else if (last_done)
    begin
      transfer_count <= cyclic_mode ? reload_count : 16'h0000;
    end
    else if (transfer_done && channel_enable && transfer_count != 16'h0000)
    begin
      transfer_count <= transfer_count - 16'h0001;
    end
  end

  // permit and end-of-block strobe towards the channel
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      transfer_permit <= 1'b0;
      block_end       <= 1'b0;
    end
    else
    begin
      transfer_permit <= channel_enable && transfer_count != 16'h0000;
      block_end       <= last_done;
    end
  end

  // ----------------------------------------------------------------
  // address pointers
  // ----------------------------------------------------------------

  // software-written pointers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      peripheral_address <= `DCC_PTR_RESET;
      memory_address     <= `DCC_PTR_RESET;
    end
    else if (wr_pend)
    begin
      if (wr_sel == dcc_pkg::DCC_SEL_PERIPH)
      begin
        peripheral_address <= hwdata;
      end
      if (wr_sel == dcc_pkg::DCC_SEL_MEMORY)
      begin
        memory_address <= hwdata;
      end
    end
  end

  // aligned addresses presented to the transfer engine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      peripheral_access_addr <= `DCC_PTR_RESET;
      memory_access_addr     <= `DCC_PTR_RESET;
    end
    else
    begin
      peripheral_access_addr <= align_addr(peripheral_address, peripheral_width);
      memory_access_addr     <= align_addr(memory_address, memory_width);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking dcc_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  count_hold_a: assert property (
    channel_enable && !transfer_done |=> $stable(transfer_count))
    else $error("count changed while enabled without a transfer");

  count_dec_a: assert property (
    transfer_done && channel_enable && transfer_count > 16'h0001
    |=> transfer_count == $past(transfer_count) - 16'h0001)
    else $error("count did not drop by one");

  zero_end_a: assert property (
    last_done && !cyclic_mode |=> transfer_count == 16'h0000 && block_end ##1 !block_end)
    else $error("count not zero after last transfer");

  cyclic_reload_a: assert property (
    last_done && cyclic_mode |=> transfer_count == $past(reload_count) && block_end)
    else $error("count not reloaded in cyclic mode");

  zero_idle_a: assert property (
    transfer_count == 16'h0000 |=> !transfer_permit)
    else $error("permit given with zero count");

  enabled_write_a: assert property (
    wr_pend && wr_sel == dcc_pkg::DCC_SEL_COUNT && channel_enable && !transfer_done
    |=> $stable(transfer_count) && $stable(reload_count))
    else $error("count write accepted while enabled");

  periph_half_a: assert property (
    peripheral_width == `DCC_WIDTH_HALF |=> peripheral_access_addr[0] == 1'b0
      && peripheral_access_addr[31:1] == $past(peripheral_address[31:1]))
    else $error("peripheral halfword alignment wrong");

  periph_word_a: assert property (
    peripheral_width == `DCC_WIDTH_WORD |=> peripheral_access_addr[1:0] == 2'b00
      && peripheral_access_addr[31:2] == $past(peripheral_address[31:2]))
    else $error("peripheral word alignment wrong");

  mem_half_a: assert property (
    memory_width == `DCC_WIDTH_HALF |=> memory_access_addr[0] == 1'b0
      && memory_access_addr[31:1] == $past(memory_address[31:1]))
    else $error("memory halfword alignment wrong");

  mem_word_a: assert property (
    memory_width == `DCC_WIDTH_WORD |=> memory_access_addr[1:0] == 2'b00
      && memory_access_addr[31:2] == $past(memory_address[31:2]))
    else $error("memory word alignment wrong");

  resv_zero_a: assert property (
    addr_phase && !hwrite && reg_sel(haddr) == dcc_pkg::DCC_SEL_COUNT
    ##2 hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("reserved count bits read non-zero");

  read_wait_a: assert property (
    addr_phase && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  permit_given_a: assert property (
    channel_enable && transfer_count != 16'h0000 |=> transfer_permit)
    else $error("permit missing with work outstanding");

  no_enable_a: assert property (
    !channel_enable |=> !transfer_permit)
    else $error("permit given while channel disabled");

  zero_done_a: assert property (
    transfer_done && channel_enable && transfer_count == 16'h0000
    |=> transfer_count == 16'h0000 && !block_end)
    else $error("transfer counted with zero count");

  count_load_a: assert property (
    wr_pend && wr_sel == dcc_pkg::DCC_SEL_COUNT && !channel_enable
    |=> transfer_count == $past(hwdata[`DCC_COUNT_MSB:0]) && reload_count == transfer_count)
    else $error("idle count write not taken");

  periph_ptr_a: assert property (
    wr_pend && wr_sel == dcc_pkg::DCC_SEL_PERIPH |=> peripheral_address == $past(hwdata))
    else $error("peripheral pointer write lost");

  mem_ptr_a: assert property (
    wr_pend && wr_sel == dcc_pkg::DCC_SEL_MEMORY |=> memory_address == $past(hwdata))
    else $error("memory pointer write lost");

  periph_byte_a: assert property (
    peripheral_width == `DCC_WIDTH_BYTE |=> peripheral_access_addr == $past(peripheral_address))
    else $error("peripheral byte address altered");

  mem_byte_a: assert property (
    memory_width == `DCC_WIDTH_BYTE |=> memory_access_addr == $past(memory_address))
    else $error("memory byte address altered");

  // main scenarios, all but wr_rd_c and zero_done_c seen by the bench
  cyc_reload_c: cover property (last_done && cyclic_mode);
  block_end_c:  cover property (last_done && !cyclic_mode);
  blocked_wr_c: cover property (wr_pend && wr_sel == dcc_pkg::DCC_SEL_COUNT && channel_enable);
  wr_rd_c:      cover property (wr_pend && addr_phase && !hwrite);
  zero_done_c:  cover property (transfer_done && channel_enable && transfer_count == 16'h0000);

endmodule : dcc_channel

// ### logic/dcc_pkg.sv
// types shared by the channel count and address block
package dcc_pkg;

  // register selected by a bus address
  typedef enum logic [1:0] {
    DCC_SEL_COUNT  = 2'b00,
    DCC_SEL_PERIPH = 2'b01,
    DCC_SEL_MEMORY = 2'b10,
    DCC_SEL_NONE   = 2'b11
  } dcc_sel_e;

  // access width code of a width field
  typedef enum logic [1:0] {
    DCC_W8   = 2'b00,
    DCC_W16  = 2'b01,
    DCC_W32  = 2'b10,
    DCC_WRES = 2'b11
  } dcc_width_e;

  typedef logic [15:0] dcc_count_t;

endpackage : dcc_pkg

// ### logic/dcc_regs.svh
// register offsets, field positions, reset values and width codes of the channel
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_OFS_COUNT     12'h070
`define DCC_OFS_PERIPH    12'h074
`define DCC_OFS_MEMORY    12'h078
`define DCC_ADDR_LSB      2
`define DCC_ADDR_MSB      11
`define DCC_COUNT_MSB     15
`define DCC_COUNT_RESET   16'h0000
`define DCC_PTR_RESET     32'h0000_0000
`define DCC_RESV_ZERO     16'h0000
`define DCC_WIDTH_BYTE    2'h0
`define DCC_WIDTH_HALF    2'h1
`define DCC_WIDTH_WORD    2'h2
`define DCC_HALF_MASK     32'hffff_fffe
`define DCC_WORD_MASK     32'hffff_fffc
`define DCC_HRESP_OKAY    1'h0

`endif

// ### testbench/dcc_channel_bench.sv
// self-checking bench of the channel count and address block
module dcc_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, took;
  logic        hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
  logic        channel_enable = 1'b0, cyclic_mode = 1'b0, exp_end = 1'b0, exp_permit = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, rng = 32'h4dc8, m_pp, m_mp;
  logic [1:0]  htrans = 2'h0, peripheral_width = 2'h0, memory_width = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  gap = 4'h0;
  wire         hreadyout, hresp, transfer_done, transfer_permit, block_end;
  wire  [31:0] hrdata, peripheral_access_addr, memory_access_addr;
  int          mismatches, comparisons, cycles, ndone, m_cnt, m_prog;

  dcc_channel dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .channel_enable, .cyclic_mode, .peripheral_width, .memory_width,
    .transfer_done, .transfer_permit, .block_end, .peripheral_access_addr, .memory_access_addr);
  dcc_far_side far (.hclk, .hresetn, .run, .gap, .transfer_permit, .transfer_done);

  // free-running bus clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // expected access address for a width code
  function automatic logic [31:0] align(input logic [31:0] p, input logic [1:0] w);
    return (w == 2'h1) ? (p & 32'hffff_fffe) : (w == 2'h2) ? (p & 32'hffff_fffc) : p;
  endfunction : align

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // single word transfer; the model follows what the slave should accept
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check(hresp, 1'b0, "okay response");
    if (wr && a == 32'h70 && !channel_enable)
    begin
      m_cnt <= wd[15:0];
      m_prog <= wd[15:0];
    end
    if (wr && a == 32'h74) m_pp = wd;
    if (wr && a == 32'h78) m_mp = wd;
  endtask : bus

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp, "read data");
  endtask : rdc

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // transfer-side model compared every cycle
  always @(posedge hclk)
  begin
    if (hresetn)
    begin
      check(block_end, exp_end, "block end");
      check(transfer_permit, exp_permit, "permit");
      took = transfer_done && channel_enable && m_cnt != 0;
      exp_end = took && m_cnt == 1;
      exp_permit = channel_enable && m_cnt != 0;
      if (took) ndone <= ndone + 1;
      if (took) m_cnt <= (m_cnt == 1) ? (cyclic_mode ? m_prog : 0) : m_cnt - 1;
    end
  end

  // hang guard
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    bus(1'b1, 32'h7c, 32'hffff_ffff);
    for (int a = 32'h70; a < 32'h80; a += 4)
      rdc(a, 32'h0);
    $display("test reset values done");
    bus(1'b1, 32'h70, 32'hffff_ffff);
    rdc(32'h70, 32'h0000_ffff);
    bus(1'b1, 32'h70, 32'h0);
    channel_enable <= 1'b1;
    run <= 1'b1;
    repeat (6) @(posedge hclk);
    rdc(32'h70, 32'h0);
    run <= 1'b0;
    channel_enable <= 1'b0;
    $display("test count range done");
    for (int w = 0; w < 4; w++)
    begin
      rng = xs(rng);
      peripheral_width <= w[1:0];
      memory_width <= 2'(3 - w);
      bus(1'b1, 32'h74, rng);
      bus(1'b1, 32'h78, ~rng);
      repeat (2) @(posedge hclk);
      check(peripheral_access_addr, align(m_pp, peripheral_width), "periph addr");
      check(memory_access_addr, align(m_mp, memory_width), "memory addr");
      rdc(32'h74, m_pp);
      rdc(32'h78, m_mp);
    end
    $display("test pointers done");
    for (int c = 0; c < 2; c++)
    begin
      rng = xs(rng);
      bus(1'b1, 32'h70, 32'h0003_0003);
      cyclic_mode <= c[0];
      channel_enable <= 1'b1;
      bus(1'b1, 32'h70, 32'h9);
      rdc(32'h70, 32'h3);
      gap <= rng[3:0] & 4'h3;
      ndone = 0;
      run <= 1'b1;
      while (ndone < 5 && !(c == 0 && m_cnt == 0)) @(posedge hclk);
      run <= 1'b0;
      repeat (4) @(posedge hclk);
      rdc(32'h70, m_cnt);
      channel_enable <= 1'b0;
      @(posedge hclk);
      $display("test counting with cyclic %0d done", c);
    end
    end_of_test();
  end
endmodule : dcc_channel_bench

// ### testbench/dcc_far_side.sv
// far-side model: peripheral and memory finishing the transfers the channel permits
module dcc_far_side (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic [3:0] gap,
  input  wire logic       transfer_permit,
  output logic            transfer_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idle;

  // one completion pulse per permitted transfer, then gap plus one idle cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idle          <= 4'h0;
      transfer_done <= 1'b0;
    end
    else if (transfer_done)
    begin
      transfer_done <= 1'b0;
      idle          <= gap;
    end
    else if (idle != 4'h0)
      idle <= idle - 4'h1;
    else
      transfer_done <= run && transfer_permit;
  end
endmodule : dcc_far_side
